// >>> snm_pkg.sv
// shared constants, types and helpers of the spi nonvolatile memory command and protection block
package snm_pkg;

	// array geometry
	localparam int          ADDR_W         = 9;
	localparam int          DATA_W         = 8;
	localparam int          MEM_DEPTH      = 512;
	localparam logic [8:0]  ADDR_LAST      = 9'h1FF;

	// opcodes; the memory opcodes carry address bit 8 in opcode bit 3
	localparam logic [7:0]  OPC_SET_LATCH  = 8'h06;
	localparam logic [7:0]  OPC_CLR_LATCH  = 8'h04;
	localparam logic [7:0]  OPC_STAT_RD    = 8'h05;
	localparam logic [7:0]  OPC_STAT_WR    = 8'h01;
	localparam logic [7:0]  OPC_MEM_MASK   = 8'hF7;
	localparam logic [7:0]  OPC_MEM_RD     = 8'h03;
	localparam logic [7:0]  OPC_MEM_WR     = 8'h02;
	localparam int          OPC_ADDR_BIT   = 3;

	// status_protect_register layout; bits 0 and 4..7 always read zero
	localparam int          ST_LATCH_BIT   = 1;
	localparam int          ST_BP_LO_BIT   = 2;
	localparam int          ST_BP_HI_BIT   = 3;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;
	localparam logic [1:0]  BP_FACTORY     = 2'h0;

	// block protect encodings and the first protected address of each
	localparam logic [1:0]  BP_NONE        = 2'h0;
	localparam logic [1:0]  BP_QUARTER     = 2'h1;
	localparam logic [1:0]  BP_HALF        = 2'h2;
	localparam logic [1:0]  BP_ALL         = 2'h3;
	localparam logic [8:0]  PROT_QUARTER_BASE = 9'h180;
	localparam logic [8:0]  PROT_HALF_BASE    = 9'h100;
	localparam logic [8:0]  PROT_ALL_BASE     = 9'h000;

	// what a finished frame asks of the latch and the protect bits
	typedef enum logic [2:0] {
		SNM_END_NONE,
		SNM_END_SET,
		SNM_END_CLEAR,
		SNM_END_STATUS,
		SNM_END_MEMWR
	} snm_end_kind_t;

	// frame outcome handed from the link clock to the system clock
	typedef struct packed {
		snm_end_kind_t kind;
		logic          stat_valid;
		logic [1:0]    stat_bp;
		logic          upper_hit;
	} snm_frame_result_t;

	// protection lookup: true when the address lies in the protected block
	function automatic logic snm_is_protected(input logic [8:0] addr, input logic [1:0] bp);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			BP_NONE:    hit = 1'b0;
			BP_QUARTER: hit = (addr >= PROT_QUARTER_BASE);
			BP_HALF:    hit = (addr >= PROT_HALF_BASE);
			BP_ALL:     hit = (addr >= PROT_ALL_BASE);
		endcase
		return hit;
	endfunction : snm_is_protected

endpackage : snm_pkg

// >>> snm_cmd_protect.sv
// spi slave command decoder, status register, write protection and 512 x 8 array
`timescale 1ns/100ps

// link-side engine: runs on the serial clock, frame state is cleared while chip select is high
module snm_link
(
	input  wire logic                        sck_i,
	input  wire logic                        cs_n_i,
	input  wire logic                        si_i,
	input  wire logic                        wp_n_i,
	input  wire logic                        link_rst_i,
	input  wire logic                        wel_i,
	input  wire logic [1:0]                  bp_i,
	output snm_pkg::snm_frame_result_t       result_o,
	output logic                             so_o,
	output logic                             so_oe_o
);

	typedef enum logic [2:0] {
		SNM_PH_OPCODE,
		SNM_PH_ADDRESS,
		SNM_PH_WR_DATA,
		SNM_PH_RD_DATA,
		SNM_PH_STAT_OUT,
		SNM_PH_STAT_IN,
		SNM_PH_IGNORE
	} snm_phase_t;

	typedef struct packed {
		snm_phase_t  phase;
		logic [2:0]  bit_cnt;
		logic [6:0]  shift;
		logic        is_read;
		logic [8:0]  addr;
		logic [7:0]  tx;
		logic        halted;
		logic        wel_s1;
		logic        wel_s2;
		logic [1:0]  bp_s1;
		logic [1:0]  bp_s2;
		logic        wp_s1;
		logic        wp_s2;
		logic        wp_s3;
	} snm_link_state_t;

	snm_link_state_t             link_reg;
	snm_link_state_t             link_next;
	snm_pkg::snm_frame_result_t  result_reg;
	snm_pkg::snm_frame_result_t  result_next;
	logic [7:0]                  mem [0:snm_pkg::MEM_DEPTH-1];
	logic                        wr_en;
	logic [7:0]                  byte_in;
	logic [7:0]                  status_byte;
	logic [8:0]                  start_addr;
	logic                        wr_ok;
	logic                        so_reg;
	logic                        so_oe_reg;

	// next state of the frame engine, evaluated at every rising serial clock edge
	always_comb
	begin
		link_next   = link_reg;
		result_next = result_reg;
		wr_en       = 1'b0;
		byte_in     = {link_reg.shift, si_i};
		start_addr  = {link_reg.addr[8], byte_in};
		status_byte = snm_pkg::STATUS_RESET;
		status_byte[snm_pkg::ST_LATCH_BIT] = link_reg.wel_s2;
		status_byte[snm_pkg::ST_BP_LO_BIT] = link_reg.bp_s2[0];
		status_byte[snm_pkg::ST_BP_HI_BIT] = link_reg.bp_s2[1];
		// a pin-level wp counts only once its two late samples agree high
		wr_ok = link_reg.wel_s2 & link_reg.wp_s2 & link_reg.wp_s3 & ~link_reg.halted;

		// status and pin samplers; stable for many edges before any use
		link_next.wel_s1 = wel_i;
		link_next.wel_s2 = link_reg.wel_s1;
		link_next.bp_s1  = bp_i;
		link_next.bp_s2  = link_reg.bp_s1;
		link_next.wp_s1  = wp_n_i;
		link_next.wp_s2  = link_reg.wp_s1;
		link_next.wp_s3  = link_reg.wp_s2;

		link_next.shift   = byte_in[6:0];
		link_next.bit_cnt = link_reg.bit_cnt + 3'h1;

		// first edge of a frame forgets the previous frame's outcome
		if (link_reg.phase == SNM_PH_OPCODE && link_reg.bit_cnt == 3'h0)
		begin
			result_next = '0;
		end

		if (link_reg.bit_cnt == 3'h7)
		begin
			unique case (link_reg.phase)
				SNM_PH_OPCODE:
				begin
					if (byte_in == snm_pkg::OPC_SET_LATCH)
					begin
						result_next.kind = snm_pkg::SNM_END_SET;
						link_next.phase  = SNM_PH_IGNORE;
					end
					else if (byte_in == snm_pkg::OPC_CLR_LATCH)
					begin
						result_next.kind = snm_pkg::SNM_END_CLEAR;
						link_next.phase  = SNM_PH_IGNORE;
					end
					else if (byte_in == snm_pkg::OPC_STAT_RD)
					begin
						link_next.tx    = status_byte;
						link_next.phase = SNM_PH_STAT_OUT;
					end
					else if (byte_in == snm_pkg::OPC_STAT_WR)
					begin
						result_next.kind = snm_pkg::SNM_END_STATUS;
						link_next.phase  = SNM_PH_STAT_IN;
					end
					else if ((byte_in & snm_pkg::OPC_MEM_MASK) == snm_pkg::OPC_MEM_RD)
					begin
						link_next.addr[8] = byte_in[snm_pkg::OPC_ADDR_BIT];
						link_next.is_read = 1'b1;
						link_next.phase   = SNM_PH_ADDRESS;
					end
					else if ((byte_in & snm_pkg::OPC_MEM_MASK) == snm_pkg::OPC_MEM_WR)
					begin
						link_next.addr[8] = byte_in[snm_pkg::OPC_ADDR_BIT];
						link_next.is_read = 1'b0;
						result_next.kind  = snm_pkg::SNM_END_MEMWR;
						link_next.phase   = SNM_PH_ADDRESS;
					end
					else
					begin
						link_next.phase = SNM_PH_IGNORE;
					end
				end
				SNM_PH_ADDRESS:
				begin
					if (link_reg.is_read)
					begin
						// first byte ready for next clocks
						link_next.tx    = mem[start_addr];
						link_next.addr  = start_addr + 9'h001;
						link_next.phase = SNM_PH_RD_DATA;
					end
					else
					begin
						link_next.addr  = start_addr;
						link_next.phase = SNM_PH_WR_DATA;
					end
				end
				SNM_PH_RD_DATA:
				begin
					link_next.tx   = mem[link_reg.addr];
					link_next.addr = link_reg.addr + 9'h001;
				end
				SNM_PH_STAT_OUT:
				begin
					// one status byte only, then the output lets go
					link_next.phase = SNM_PH_IGNORE;
				end
				SNM_PH_STAT_IN:
				begin
					// only the protect field is taken
					result_next.stat_valid = 1'b1;
					result_next.stat_bp    = {byte_in[snm_pkg::ST_BP_HI_BIT], byte_in[snm_pkg::ST_BP_LO_BIT]};
					link_next.phase        = SNM_PH_IGNORE;
				end
				SNM_PH_WR_DATA:
				begin
					if (!link_reg.halted && snm_pkg::snm_is_protected(link_reg.addr, link_reg.bp_s2))
					begin
						link_next.halted = 1'b1;
					end
					else if (wr_ok)
					begin
						wr_en                 = 1'b1;
						result_next.upper_hit = result_reg.upper_hit | link_reg.addr[8];
						link_next.addr        = link_reg.addr + 9'h001;
					end
					else if (!link_reg.halted)
					begin
						link_next.addr = link_reg.addr + 9'h001;
					end
				end
				SNM_PH_IGNORE:
				begin
					link_next.phase = SNM_PH_IGNORE;
				end
			endcase
		end
	end

	// frame state held cleared while deselected
	always_ff @(posedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			link_reg <= '0;
		else
			link_reg <= link_next;
	end

	// frame outcome survives the chip-select rise so the system side can act on it
	always_ff @(posedge sck_i or posedge link_rst_i)
	begin
		if (link_rst_i)
			result_reg <= '0;
		else if (!cs_n_i)
			result_reg <= result_next;
	end

	// array has no reset: contents are nonvolatile; partial bytes never reach wr_en
	always_ff @(posedge sck_i)
	begin
		if (wr_en)
			mem[link_reg.addr] <= byte_in;
	end

	// output released as chip select rises
	always_ff @(negedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			so_reg    <= 1'b0;
			so_oe_reg <= 1'b0;
		end
		else
		begin
			so_oe_reg <= (link_reg.phase == SNM_PH_RD_DATA) || (link_reg.phase == SNM_PH_STAT_OUT);
			so_reg    <= link_reg.tx[~link_reg.bit_cnt];
		end
	end

	assign result_o = result_reg;
	assign so_o     = so_reg;
	assign so_oe_o  = so_oe_reg;

endmodule : snm_link

// What this block does
// - latch starts cleared after power-up
// - only set-latch command sets latch bit
// - frame end clears latch after status writes and after memory writes that stored no upper-half byte
// - upper-half memory write keeps latch set
// - clear-latch command clears latch
// - low protect pin refuses all writes
// - status bits 3:2 protect, 1 latch
// - protect bits nonvolatile, factory zero; here every reset reloads the factory zero
// - protect code selects protected range
// - writes need latch set and pin high
// - status read returns one status byte
// - status write gated by latch and pin
// - write opcode bit 3 is address bit 8
// - write bytes stored sequentially, wrapping
// - each byte committed at eighth bit
// - protected address stops burst write
// - chip select rise ends memory write
// - read opcode bit 3 is address bit 8
// - read data follows address, input ignored
// - sequential read with wrap-around
// - chip select rise ends read, tristate
// - opcode values decode six commands
// - unknown opcode ignored until reselect
// - sample rising edge, drive falling edge
// - deselected device ignores input, tristate
module snm_cmd_protect
#(
	parameter int ADDR_W    = snm_pkg::ADDR_W,
	parameter int MEM_DEPTH = snm_pkg::MEM_DEPTH
)
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        si_i,
	input  wire logic        wp_n_i,
	output logic             so_o,
	output logic             so_oe_o,
	output logic [7:0]       status_o
);

	typedef struct packed {
		logic                        cs_s1;
		logic                        cs_s2;
		logic                        cs_s3;
		logic                        cs_level;
		logic                        wp_s1;
		logic                        wp_s2;
		logic                        wp_s3;
		logic                        wp_level;
		snm_pkg::snm_frame_result_t  res_s1;
		snm_pkg::snm_frame_result_t  res_s2;
		logic                        write_latch_flag;
		logic [1:0]                  bp;
		logic                        link_rst;
		logic [7:0]                  status;
	} snm_sys_state_t;

	snm_sys_state_t              sys_reg;
	snm_sys_state_t              sys_next;
	snm_pkg::snm_frame_result_t  link_result;
	logic                        cs_rise;

	// the array is fixed at 512 bytes addressed by 9 bits
	if (ADDR_W != snm_pkg::ADDR_W || MEM_DEPTH != (1 << ADDR_W))
	begin : g_bad_geometry
		$error("snm_cmd_protect supports only a 9-bit address over 512 bytes");
	end

	snm_link u_link
	(
		.sck_i      (sck_i),
		.cs_n_i     (cs_n_i),
		.si_i       (si_i),
		.wp_n_i     (wp_n_i),
		.link_rst_i (sys_reg.link_rst),
		.wel_i      (sys_reg.write_latch_flag),
		.bp_i       (sys_reg.bp),
		.result_o   (link_result),
		.so_o       (so_o),
		.so_oe_o    (so_oe_o)
	);

	// frame outcomes are applied here once the chip-select rise has been seen on clk_i
	always_comb
	begin
		sys_next          = sys_reg;
		sys_next.link_rst = 1'b0;
		// chip select and wp pass three flops; a level counts once the last two agree
		sys_next.cs_s1    = cs_n_i;
		sys_next.cs_s2    = sys_reg.cs_s1;
		sys_next.cs_s3    = sys_reg.cs_s2;
		sys_next.wp_s1    = wp_n_i;
		sys_next.wp_s2    = sys_reg.wp_s1;
		sys_next.wp_s3    = sys_reg.wp_s2;
		// outcome is stable from the last serial edge on, two flops suffice
		sys_next.res_s1   = link_result;
		sys_next.res_s2   = sys_reg.res_s1;
		if (sys_reg.cs_s2 == sys_reg.cs_s3)
			sys_next.cs_level = sys_reg.cs_s3;
		if (sys_reg.wp_s2 == sys_reg.wp_s3)
			sys_next.wp_level = sys_reg.wp_s3;
		cs_rise = sys_reg.cs_s2 & sys_reg.cs_s3 & ~sys_reg.cs_level;

		if (cs_rise)
		begin
			unique case (sys_reg.res_s2.kind)
				snm_pkg::SNM_END_SET:
				begin
					sys_next.write_latch_flag = 1'b1;
				end
				snm_pkg::SNM_END_CLEAR:
				begin
					sys_next.write_latch_flag = 1'b0;
				end
				snm_pkg::SNM_END_STATUS:
				begin
					if (sys_reg.write_latch_flag && sys_reg.wp_level && sys_reg.res_s2.stat_valid)
						sys_next.bp = sys_reg.res_s2.stat_bp;
					sys_next.write_latch_flag = 1'b0;
				end
				snm_pkg::SNM_END_MEMWR:
				begin
					if (!sys_reg.res_s2.upper_hit)
						sys_next.write_latch_flag = 1'b0;
				end
				snm_pkg::SNM_END_NONE:
				begin
					sys_next.write_latch_flag = sys_reg.write_latch_flag;
				end
				default:
				begin
					sys_next.write_latch_flag = sys_reg.write_latch_flag;
				end
			endcase
		end

		sys_next.status = snm_pkg::STATUS_RESET;
		sys_next.status[snm_pkg::ST_LATCH_BIT] = sys_next.write_latch_flag;
		sys_next.status[snm_pkg::ST_BP_LO_BIT] = sys_next.bp[0];
		sys_next.status[snm_pkg::ST_BP_HI_BIT] = sys_next.bp[1];
	end

	// protect bits start at factory value
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			sys_reg          <= '0;
			sys_reg.cs_s1    <= 1'b1;
			sys_reg.cs_s2    <= 1'b1;
			sys_reg.cs_s3    <= 1'b1;
			sys_reg.cs_level <= 1'b1;
			sys_reg.bp       <= snm_pkg::BP_FACTORY;
			sys_reg.status   <= snm_pkg::STATUS_RESET;
			sys_reg.link_rst <= 1'b1;
		end
		else
		begin
			sys_reg <= sys_next;
		end
	end

	assign status_o = sys_reg.status;

endmodule : snm_cmd_protect

// >>> snm_cmd_protect_monitor.sv
// port checker of the spi memory command and protection block
`timescale 1ns/100ps
module snm_cmd_protect_monitor
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       sck_i,
	input wire logic       cs_n_i,
	input wire logic       si_i,
	input wire logic       wp_n_i,
	input wire logic       so_o,
	input wire logic       so_oe_o,
	input wire logic [7:0] status_o
);
	logic [7:0] bit_reg;

	// sck rising edges since select; deselect clears it at once
	always_ff @(posedge sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			bit_reg <= 8'h00;
		else if (bit_reg != 8'hFF)
			bit_reg <= bit_reg + 8'h01;
	end

	reset_zero_a: assert property (@(posedge clk_i)
		$rose(reset_n_i) |-> status_o == 8'h00)
		else $error("status not zero after reset");
	fixed_bits_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		status_o[7:4] == 4'h0 && !status_o[0])
		else $error("fixed status bits not zero");
	deselect_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cs_n_i && $past(cs_n_i) |-> !so_oe_o)
		else $error("so driven while deselected");
	protect_pin_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$changed(status_o[3:2]) |-> wp_n_i)
		else $error("protect bits moved with pin low");
	protect_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$changed(status_o[3:2]) |-> $past(status_o[1]) && !status_o[1])
		else $error("protect bits moved without latch");
	drive_fall_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!cs_n_i && $past(!cs_n_i) && ($changed(so_o) || $rose(so_oe_o)) |-> !sck_i)
		else $error("so moved while sck high");
	oe_hold_a: assert property (@(posedge sck_i) disable iff (cs_n_i)
		$rose(so_oe_o) |-> so_oe_o [*8])
		else $error("so enable shorter than a byte");
	// answer only after opcode or address
	answer_time_a: assert property (@(posedge sck_i) disable iff (cs_n_i)
		$rose(so_oe_o) |-> bit_reg == 8'h08 || bit_reg == 8'h10)
		else $error("so enabled at wrong bit");
endmodule : snm_cmd_protect_monitor

bind snm_cmd_protect snm_cmd_protect_monitor u_snm_cmd_protect_monitor
(
	.clk_i,
	.reset_n_i,
	.sck_i,
	.cs_n_i,
	.si_i,
	.wp_n_i,
	.so_o,
	.so_oe_o,
	.status_o
);

// >>> snm_spi_master.sv
// behavioural spi master on the far side of the serial link
`timescale 1ns/100ps
module snm_spi_master
(
	input  wire logic  so_i,
	output logic       sck_o,
	output logic       cs_n_o,
	output logic       si_o,
	output logic       rx_tg_o,
	output logic [7:0] rx_byte_o
);
	logic mode3;

	// idle bus: deselected, clock standing still
	initial
	begin
		mode3 = 1'b0;
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		rx_tg_o = 1'b0;
		rx_byte_o = 8'h00;
	end

	// idle clock level at select picks mode 0 or 3
	task automatic start(input logic m3);
		mode3 = m3;
		sck_o = m3;
		#7;
		cs_n_o = 1'b0;
		#16;
	endtask : start

	// si moves after falling edge, so taken at rising edge
	task automatic xfer(input logic [7:0] tx, input int nb, input logic chk);
		logic [7:0] rx;
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--)
		begin
			sck_o = 1'b0;
			#1;
			si_o = tx[i];
			#15;
			sck_o = 1'b1;
			rx[i] = so_i;
			#16;
		end
		rx_byte_o = rx;
		// a toggle marks a byte the bench wants compared
		if (chk)
			rx_tg_o = ~rx_tg_o;
	endtask : xfer

	// back to idle level, then deselect; si turns to junk
	task automatic stop();
		sck_o = mode3;
		#16;
		cs_n_o = 1'b1;
		si_o = ~si_o;
	endtask : stop
endmodule : snm_spi_master

// >>> snm_cmd_protect_tb_top.sv
// self-checking bench of the spi memory command and protection block
`timescale 1ns/100ps
module snm_cmd_protect_tb_top;
	logic        clk;
	logic        reset_n;
	logic        wp_n;
	logic        mode3;
	logic        oe_seen;
	logic        sck;
	logic        cs_n;
	logic        si;
	logic        so;
	logic        so_oe;
	logic        rx_tg;
	logic [7:0]  rx_byte;
	logic [7:0]  status;
	logic [31:0] rnd = 32'h24;
	logic        latch_m;
	logic [1:0]  bp_m;
	logic [8:0]  base;
	logic [7:0]  mem_m [512];
	bit          known_m [512];
	logic [7:0]  note_q [$];
	int          fails = 0;
	int          n_compared = 0;

	// released so line shows the inverse of its last value, so a late sample cannot pass by luck
	snm_cmd_protect u_snm_cmd_protect
	(
		.clk_i     (clk),
		.reset_n_i (reset_n),
		.sck_i     (sck),
		.cs_n_i    (cs_n),
		.si_i      (si),
		.wp_n_i    (wp_n),
		.so_o      (so),
		.so_oe_o   (so_oe),
		.status_o  (status)
	);
	snm_spi_master u_snm_spi_master
	(
		.so_i      (so_oe ? so : ~so),
		.sck_o     (sck),
		.cs_n_o    (cs_n),
		.si_o      (si),
		.rx_tg_o   (rx_tg),
		.rx_byte_o (rx_byte)
	);

	// system clock
	initial
	begin
		clk = 1'b0;
		forever
			#5 clk = ~clk;
	end

	// xorshift source of data and junk bits
	function automatic logic [7:0] rb();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd[7:0];
	endfunction : rb

	// protected range of the current code
	function automatic logic prot(input logic [8:0] a);
		return (bp_m == 2'h3) || (bp_m == 2'h2 && a[8]) || (bp_m == 2'h1 && a[8:7] == 2'h3);
	endfunction : prot

	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// oldest note against each returned byte
	always @(rx_tg)
	begin
		if (note_q.size() != 0)
			cmp("so_byte", note_q.pop_front(), rx_byte);
	end

	always @(posedge so_oe)
		oe_seen = 1'b1;

	task automatic begin_f(input logic [7:0] op);
		@(negedge clk);
		u_snm_spi_master.start(mode3);
		u_snm_spi_master.xfer(op, 8, 1'b0);
	endtask : begin_f

	// frame outcome needs a few clk cycles to reach the status
	task automatic end_f();
		u_snm_spi_master.stop();
		repeat (12) @(negedge clk);
	endtask : end_f

	task automatic cmd(input logic [7:0] op);
		begin_f(op);
		end_f();
		if (op == snm_pkg::OPC_SET_LATCH)
			latch_m = 1'b1;
		if (op == snm_pkg::OPC_CLR_LATCH)
			latch_m = 1'b0;
	endtask : cmd

	task automatic wr_st(input logic [7:0] d);
		begin_f(snm_pkg::OPC_STAT_WR);
		u_snm_spi_master.xfer(d, 8, 1'b0);
		end_f();
		if (latch_m && wp_n)
			bp_m = d[3:2];
		latch_m = 1'b0;
	endtask : wr_st

	task automatic rd_st();
		begin_f(snm_pkg::OPC_STAT_RD);
		note_q.push_back({4'h0, bp_m, latch_m, 1'b0});
		u_snm_spi_master.xfer(rb(), 8, 1'b1);
		end_f();
		cmp("status_o", {4'h0, bp_m, latch_m, 1'b0}, status);
	endtask : rd_st

	// burst write; model halts at a protected address
	task automatic wr_mem(input logic [8:0] a, input int n, input logic part);
		logic [7:0] d;
		logic       halt;
		logic       up;
		halt = 1'b0;
		up = 1'b0;
		begin_f(snm_pkg::OPC_MEM_WR | {4'h0, a[8], 3'h0});
		u_snm_spi_master.xfer(a[7:0], 8, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			d = rb();
			u_snm_spi_master.xfer(d, 8, 1'b0);
			halt |= prot(a);
			if (!halt && latch_m && wp_n)
			begin
				mem_m[a] = d;
				known_m[a] = 1'b1;
				up |= a[8];
			end
			if (!halt)
				a++;
		end
		if (part)
			u_snm_spi_master.xfer(rb(), 5, 1'b0);
		end_f();
		latch_m &= up;
	endtask : wr_mem

	task automatic rd_mem(input logic [8:0] a, input int n);
		begin_f(snm_pkg::OPC_MEM_RD | {4'h0, a[8], 3'h0});
		u_snm_spi_master.xfer(a[7:0], 8, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			if (known_m[a])
				note_q.push_back(mem_m[a]);
			u_snm_spi_master.xfer(rb(), 8, known_m[a]);
			a++;
		end
		end_f();
	endtask : rd_mem

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// main sequence
	initial
	begin
		reset_n = 1'b0;
		wp_n = 1'b1;
		mode3 = 1'b0;
		latch_m = 1'b0;
		bp_m = 2'h0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		rd_st();
		wr_mem(9'h040, 2, 1'b0);
		cmd(snm_pkg::OPC_SET_LATCH);
		rd_st();
		cmd(snm_pkg::OPC_CLR_LATCH);
		rd_st();
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_st(8'hFF);
		rd_st();
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_st(8'h00);
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_mem(9'h1FE, 3, 1'b0);
		rd_st();
		wr_mem(9'h040, 2, 1'b0);
		rd_st();
		rd_mem(9'h1FE, 4);
		wp_n = 1'b0;
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_mem(9'h041, 1, 1'b0);
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_st(8'h0C);
		rd_st();
		wp_n = 1'b1;
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_mem(9'h03F, 1, 1'b1);
		rd_mem(9'h03F, 3);
		// every protect code, spi mode alternating
		for (int k = 0; k < 4; k++)
		begin
			mode3 = k[0];
			cmd(snm_pkg::OPC_SET_LATCH);
			wr_st({4'h0, 2'(k + 1), 2'h0});
			base = (bp_m == 2'h1) ? 9'h180 : (bp_m == 2'h2) ? 9'h100 : (bp_m == 2'h3) ? 9'h000 : 9'h0F0;
			cmd(snm_pkg::OPC_SET_LATCH);
			wr_mem(base - 9'h001, 3, 1'b0);
			rd_mem(base - 9'h001, 2);
			rd_st();
		end
		// unknown opcode: rest of frame ignored, so stays released
		oe_seen = 1'b0;
		begin_f(8'hFF);
		u_snm_spi_master.xfer(snm_pkg::OPC_SET_LATCH, 8, 1'b0);
		end_f();
		cmp("so_enable", 8'h00, {7'h00, oe_seen});
		rd_st();
		// second reset: factory protect code back, array kept
		cmd(snm_pkg::OPC_SET_LATCH);
		wr_st(8'h08);
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		latch_m = 1'b0;
		bp_m = 2'h0;
		repeat (4) @(negedge clk);
		rd_st();
		rd_mem(9'h03F, 3);
		final_report();
	end

	// cut a hang short
	initial
	begin
		#500000;
		fails++;
		final_report();
	end
endmodule : snm_cmd_protect_tb_top
